// ### src/pdmc_pkg.sv
/*
  Constants for the power-down mode controller: register map, field positions, reset values.
  Assumes an AXI4-Lite slave on a 32-bit bus at 50 MHz.
*/
package pdmc_pkg;
  localparam logic [31:0] ADDR_CTRL_A = 32'hFFFFFE91;
  localparam logic [31:0] ADDR_CTRL_B = 32'hFFFFFE93;
  localparam logic [31:0] ADDR_STATUS = 32'hFFFFFE94;
  localparam logic [7:0] CTRL_A_RESET = 8'h00;
  localparam logic [7:0] CTRL_B_RESET = 8'h00;
  localparam logic [7:0] CTRL_A_WMASK = 8'hFA;
  localparam logic [7:0] CTRL_B_WMASK = 8'h3F;
  localparam int BIT_STANDBY = 7;
  localparam int BIT_FLOAT = 6;
  localparam int BIT_BRK_STOP = 5;
  localparam int BIT_DMA_STOP = 4;
  localparam int BIT_SP_STOP = 3;
  localparam int BIT_TMR_STOP = 1;
  localparam int BIT_TPU_STOP = 5;
  localparam int BIT_SS2_STOP = 4;
  localparam int BIT_SS1_STOP = 3;
  localparam int BIT_FSER_STOP = 2;
  localparam int BIT_AS2_STOP = 1;
  localparam int BIT_AS1_STOP = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    PDMC_RUN = 2'h0,
    PDMC_SLEEP = 2'h1,
    PDMC_STANDBY = 2'h2
  } pdmc_mode_t;
endpackage : pdmc_pkg

// ### src/pdmc_top.sv
/*
  Power-down mode controller: sleep and standby sequencing, per-module clock-stop enables,
  two 8-bit control registers and a status register behind an AXI4-Lite slave.
  Assumes the core pulses sleep_exec for one cycle, wake sources are synchronous to aclk,
  and dma_busy comes from logic on the same clock.
*/
`timescale 1ns/10ps
// Function
// - Sleep instruction with standby select 0 halts core, cache, DSP; rest runs.
// - Sleep instruction with standby select 1 halts oscillator, core, bus, peripherals.
// - Sleep ends on accepted interrupt, DMA address error, power-on or manual reset.
// - Pin float select: 0 keeps output pins driven, 1 floats them in standby.
// - Any reset clears control register A to zero.
// - Break unit clock stop gates its clock; its registers hold.
// - DMA clock stop gates DMA clock and keeps state; clearing resumes it.
// - DMA clock stop cannot take effect while DMA transfers; set it when idle.
// - Signal-processing clock stop gates that clock; results are retained.
// - Timer clock stop halts timer and resets its registers; clearing restarts fresh.
// - Reserved bits 2 and 0 of register A read zero; software writes zero.
// - Both registers are 8 bits at fixed addresses; register B resets to zero.
// - Register B stops pulse timer, serial channels; async channels reset while stopped.
module pdmc_top (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels.
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core, wake sources and DMA busy.
  input wire logic sleep_exec,
  input wire logic irq_accepted,
  input wire logic dma_addr_error,
  input wire logic nmi,
  input wire logic dma_busy,
  // Power and clock enables, module resets, pin float and mode state.
  output logic core_clk_en,
  output logic sp_clk_en,
  output logic osc_run,
  output logic bus_clk_en,
  output logic periph_clk_en,
  output logic brk_clk_en,
  output logic dma_clk_en,
  output logic tmr_clk_en,
  output logic tmr_reset,
  output logic tpu_clk_en,
  output logic ss1_clk_en,
  output logic ss2_clk_en,
  output logic fser_clk_en,
  output logic as1_clk_en,
  output logic as1_reset,
  output logic as2_clk_en,
  output logic as2_reset,
  output logic pin_float,
  output logic [1:0] mode_state
);

  // Register state.
  logic [7:0] ctrl_a, next_ctrl_a;
  logic [7:0] ctrl_b, next_ctrl_b;
  pdmc_pkg::pdmc_mode_t mode, next_mode;
  logic dma_stop_eff, next_dma_stop_eff;

  // Bus state.
  logic aw_hold, next_aw_hold;
  logic [31:0] aw_addr, next_aw_addr;
  logic w_hold, next_w_hold;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid_q, next_bvalid_q;
  logic [1:0] bresp_q, next_bresp_q;
  logic rvalid_q, next_rvalid_q;
  logic [31:0] rdata_q, next_rdata_q;
  logic [1:0] rresp_q, next_rresp_q;
  logic awready_q, wready_q, arready_q;

  // Byte lane of an address within its word; registers are byte wide.
  function automatic logic [7:0] lane_byte(input logic [31:0] word, input logic [31:0] addr);
    lane_byte = word[{addr[1:0], 3'h0} +: 8];
  endfunction : lane_byte
  function automatic logic lane_strb(input logic [3:0] strb, input logic [31:0] addr);
    lane_strb = strb[addr[1:0]];
  endfunction : lane_strb
  function automatic logic [31:0] place_byte(input logic [7:0] b, input logic [31:0] addr);
    place_byte = {24'h000000, b} << {addr[1:0], 3'h0};
  endfunction : place_byte

  // Write path and register updates.
  always_comb begin
    next_aw_hold = aw_hold;
    next_aw_addr = aw_addr;
    next_w_hold = w_hold;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid_q = bvalid_q;
    next_bresp_q = bresp_q;
    next_ctrl_a = ctrl_a;
    next_ctrl_b = ctrl_b;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_hold = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_hold = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid_q = 1'b0;
    end
    if (aw_hold && w_hold && !bvalid_q) begin
      next_aw_hold = 1'b0;
      next_w_hold = 1'b0;
      next_bvalid_q = 1'b1;
      next_bresp_q = pdmc_pkg::RESP_OKAY;
      if ({aw_addr[31:2], 2'h0} == {pdmc_pkg::ADDR_CTRL_A[31:2], 2'h0}) begin
        if (lane_strb(w_strb, pdmc_pkg::ADDR_CTRL_A)) begin
          next_ctrl_a = lane_byte(w_data, pdmc_pkg::ADDR_CTRL_A) &
                        pdmc_pkg::CTRL_A_WMASK;
        end
        if (lane_strb(w_strb, pdmc_pkg::ADDR_CTRL_B)) begin
          next_ctrl_b = lane_byte(w_data, pdmc_pkg::ADDR_CTRL_B) &
                        pdmc_pkg::CTRL_B_WMASK;
        end
      end else begin
        next_bresp_q = pdmc_pkg::RESP_SLVERR;
      end
    end
  end

  // Read path.
  always_comb begin
    logic [31:0] word;
    word = 32'h00000000;
    next_rvalid_q = rvalid_q;
    next_rdata_q = rdata_q;
    next_rresp_q = rresp_q;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid_q = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid_q = 1'b1;
      next_rresp_q = pdmc_pkg::RESP_OKAY;
      if ({s_axi_araddr[31:2], 2'h0} == {pdmc_pkg::ADDR_CTRL_A[31:2], 2'h0}) begin
        word = place_byte(ctrl_a, pdmc_pkg::ADDR_CTRL_A) |
               place_byte(ctrl_b, pdmc_pkg::ADDR_CTRL_B);
      end else if (s_axi_araddr[31:2] == pdmc_pkg::ADDR_STATUS[31:2]) begin
        word = {29'h00000000, dma_stop_eff, mode};
      end else begin
        next_rresp_q = pdmc_pkg::RESP_SLVERR;
      end
      next_rdata_q = word;
    end
  end

  // Mode sequencing.
  always_comb begin
    next_mode = mode;
    next_dma_stop_eff = dma_stop_eff;
    unique case (mode)
      pdmc_pkg::PDMC_RUN: begin
        if (sleep_exec) begin
          next_mode = ctrl_a[pdmc_pkg::BIT_STANDBY] ? pdmc_pkg::PDMC_STANDBY
                                                    : pdmc_pkg::PDMC_SLEEP;
        end
      end
      pdmc_pkg::PDMC_SLEEP: begin
        if (irq_accepted || dma_addr_error || nmi) begin
          next_mode = pdmc_pkg::PDMC_RUN;
        end
      end
      pdmc_pkg::PDMC_STANDBY: begin
        if (nmi) begin
          next_mode = pdmc_pkg::PDMC_RUN;
        end
      end
      default: next_mode = pdmc_pkg::PDMC_RUN;
    endcase
    // A stop request waits for the transfer to finish, so no burst is cut short.
    if (!ctrl_a[pdmc_pkg::BIT_DMA_STOP]) begin
      next_dma_stop_eff = 1'b0;
    end else if (!dma_busy) begin
      next_dma_stop_eff = 1'b1;
    end
  end

  // Registers; every reset source arrives as aresetn.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_a <= pdmc_pkg::CTRL_A_RESET;
      ctrl_b <= pdmc_pkg::CTRL_B_RESET;
      mode <= pdmc_pkg::PDMC_RUN;
      dma_stop_eff <= 1'b0;
      aw_hold <= 1'b0;
      aw_addr <= 32'h00000000;
      w_hold <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= 2'h0;
    end else begin
      ctrl_a <= next_ctrl_a;
      ctrl_b <= next_ctrl_b;
      mode <= next_mode;
      dma_stop_eff <= next_dma_stop_eff;
      aw_hold <= next_aw_hold;
      aw_addr <= next_aw_addr;
      w_hold <= next_w_hold;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid_q <= next_bvalid_q;
      bresp_q <= next_bresp_q;
      rvalid_q <= next_rvalid_q;
      rdata_q <= next_rdata_q;
      rresp_q <= next_rresp_q;
    end
  end

  // Registered enables follow the next state so they change with the mode.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_clk_en <= 1'b1;
      sp_clk_en <= 1'b1;
      osc_run <= 1'b1;
      bus_clk_en <= 1'b1;
      periph_clk_en <= 1'b1;
      brk_clk_en <= 1'b1;
      dma_clk_en <= 1'b1;
      tmr_clk_en <= 1'b1;
      tmr_reset <= 1'b0;
      tpu_clk_en <= 1'b1;
      ss1_clk_en <= 1'b1;
      ss2_clk_en <= 1'b1;
      fser_clk_en <= 1'b1;
      as1_clk_en <= 1'b1;
      as1_reset <= 1'b0;
      as2_clk_en <= 1'b1;
      as2_reset <= 1'b0;
      pin_float <= 1'b0;
      mode_state <= 2'h0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      arready_q <= 1'b1;
    end else begin
      core_clk_en <= next_mode == pdmc_pkg::PDMC_RUN;
      sp_clk_en <= next_mode == pdmc_pkg::PDMC_RUN &&
                   !next_ctrl_a[pdmc_pkg::BIT_SP_STOP];
      osc_run <= next_mode != pdmc_pkg::PDMC_STANDBY;
      bus_clk_en <= next_mode != pdmc_pkg::PDMC_STANDBY;
      periph_clk_en <= next_mode != pdmc_pkg::PDMC_STANDBY;
      brk_clk_en <= next_mode != pdmc_pkg::PDMC_STANDBY &&
                    !next_ctrl_a[pdmc_pkg::BIT_BRK_STOP];
      dma_clk_en <= next_mode != pdmc_pkg::PDMC_STANDBY && !next_dma_stop_eff;
      tmr_clk_en <= next_mode != pdmc_pkg::PDMC_STANDBY &&
                    !next_ctrl_a[pdmc_pkg::BIT_TMR_STOP];
      tmr_reset <= next_ctrl_a[pdmc_pkg::BIT_TMR_STOP];
      tpu_clk_en <= next_mode != pdmc_pkg::PDMC_STANDBY &&
                    !next_ctrl_b[pdmc_pkg::BIT_TPU_STOP];
      ss1_clk_en <= next_mode != pdmc_pkg::PDMC_STANDBY &&
                    !next_ctrl_b[pdmc_pkg::BIT_SS1_STOP];
      ss2_clk_en <= next_mode != pdmc_pkg::PDMC_STANDBY &&
                    !next_ctrl_b[pdmc_pkg::BIT_SS2_STOP];
      fser_clk_en <= next_mode != pdmc_pkg::PDMC_STANDBY &&
                     !next_ctrl_b[pdmc_pkg::BIT_FSER_STOP];
      as1_clk_en <= next_mode != pdmc_pkg::PDMC_STANDBY &&
                    !next_ctrl_b[pdmc_pkg::BIT_AS1_STOP];
      as1_reset <= next_ctrl_b[pdmc_pkg::BIT_AS1_STOP];
      as2_clk_en <= next_mode != pdmc_pkg::PDMC_STANDBY &&
                    !next_ctrl_b[pdmc_pkg::BIT_AS2_STOP];
      as2_reset <= next_ctrl_b[pdmc_pkg::BIT_AS2_STOP];
      pin_float <= next_mode == pdmc_pkg::PDMC_STANDBY &&
                   next_ctrl_a[pdmc_pkg::BIT_FLOAT];
      mode_state <= next_mode;
      // Ready flags are flopped from the next hold and read-valid state, so no bus output leaves a gate.
      awready_q <= !next_aw_hold;
      wready_q <= !next_w_hold;
      arready_q <= !next_rvalid_q;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Checks.
  property p_sleep_entry;
    @(posedge aclk) disable iff (!aresetn)
    (mode == pdmc_pkg::PDMC_RUN && sleep_exec && !ctrl_a[pdmc_pkg::BIT_STANDBY])
      |=> (mode == pdmc_pkg::PDMC_SLEEP && !core_clk_en && periph_clk_en && osc_run);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry wrong");
  property p_standby_entry;
    @(posedge aclk) disable iff (!aresetn)
    (mode == pdmc_pkg::PDMC_RUN && sleep_exec && ctrl_a[pdmc_pkg::BIT_STANDBY])
      |=> (!osc_run && !bus_clk_en && !periph_clk_en && !core_clk_en);
  endproperty
  a_standby_entry: assert property (p_standby_entry) else $error("standby entry wrong");
  property p_sleep_exit;
    @(posedge aclk) disable iff (!aresetn)
    (mode == pdmc_pkg::PDMC_SLEEP && (irq_accepted || dma_addr_error)) |=> core_clk_en;
  endproperty
  a_sleep_exit: assert property (p_sleep_exit) else $error("sleep not left");
  property p_standby_hold;
    @(posedge aclk) disable iff (!aresetn)
    (mode == pdmc_pkg::PDMC_STANDBY && !nmi) |=> mode == pdmc_pkg::PDMC_STANDBY;
  endproperty
  a_standby_hold: assert property (p_standby_hold) else $error("standby left early");
  property p_float;
    @(posedge aclk) disable iff (!aresetn)
    pin_float |-> (mode == pdmc_pkg::PDMC_STANDBY && ctrl_a[pdmc_pkg::BIT_FLOAT]);
  endproperty
  a_float: assert property (p_float) else $error("pins float outside standby");
  property p_reserved;
    @(posedge aclk) disable iff (!aresetn)
    (ctrl_a[2] == 1'b0 && ctrl_a[0] == 1'b0 && ctrl_b[7:6] == 2'h0);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");
  property p_dma_busy;
    @(posedge aclk) disable iff (!aresetn)
    (dma_busy && !dma_stop_eff) |=> !dma_stop_eff;
  endproperty
  a_dma_busy: assert property (p_dma_busy) else $error("dma stopped while busy");
  property p_timer;
    @(posedge aclk) disable iff (!aresetn)
    ctrl_a[pdmc_pkg::BIT_TMR_STOP] |-> (tmr_reset && !tmr_clk_en);
  endproperty
  a_timer: assert property (p_timer) else $error("timer not held");
  property p_brk;
    @(posedge aclk) disable iff (!aresetn)
    ctrl_a[pdmc_pkg::BIT_BRK_STOP] |-> !brk_clk_en;
  endproperty
  a_brk: assert property (p_brk) else $error("break clock runs");
  property p_async;
    @(posedge aclk) disable iff (!aresetn)
    ctrl_b[pdmc_pkg::BIT_AS1_STOP] |-> (as1_reset && !as1_clk_en);
  endproperty
  a_async: assert property (p_async) else $error("async channel not held");

endmodule : pdmc_top

// ### sim/pdmc_top_tb.sv
/*
  Self-checking bench for the power-down mode controller: AXI4-Lite register access,
  sleep and standby entry and wake, per-module clock stops.
  Assumes the package constants and a 50 MHz aclk; all inputs driven by this bench.
*/
`timescale 1ns/10ps
module pdmc_top_tb;
  logic aclk, aresetn;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, mode_state, r;
  logic sleep_exec, irq_accepted, dma_addr_error, nmi, dma_busy;
  logic core_clk_en, sp_clk_en, osc_run, bus_clk_en, periph_clk_en, brk_clk_en, dma_clk_en;
  logic tmr_clk_en, tmr_reset, tpu_clk_en, ss1_clk_en, ss2_clk_en, fser_clk_en;
  logic as1_clk_en, as1_reset, as2_clk_en, as2_reset, pin_float;
  logic [31:0] d;
  int miscompares, cmp_count;
  localparam logic [31:0] WORD = 32'hFFFFFE90;
  wire logic [4:0] core_grp = {core_clk_en, sp_clk_en, osc_run, bus_clk_en, periph_clk_en};
  wire logic [4:0] a_grp = {brk_clk_en, dma_clk_en, sp_clk_en, tmr_clk_en, tmr_reset};
  wire logic [7:0] b_grp = {tpu_clk_en, ss2_clk_en, ss1_clk_en, fser_clk_en, as2_clk_en,
    as1_clk_en, as2_reset, as1_reset};

  pdmc_top pdmc_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .sleep_exec(sleep_exec), .irq_accepted(irq_accepted),
    .dma_addr_error(dma_addr_error), .nmi(nmi), .dma_busy(dma_busy),
    .core_clk_en(core_clk_en), .sp_clk_en(sp_clk_en), .osc_run(osc_run),
    .bus_clk_en(bus_clk_en), .periph_clk_en(periph_clk_en), .brk_clk_en(brk_clk_en),
    .dma_clk_en(dma_clk_en), .tmr_clk_en(tmr_clk_en), .tmr_reset(tmr_reset),
    .tpu_clk_en(tpu_clk_en), .ss1_clk_en(ss1_clk_en), .ss2_clk_en(ss2_clk_en),
    .fser_clk_en(fser_clk_en), .as1_clk_en(as1_clk_en), .as1_reset(as1_reset),
    .as2_clk_en(as2_clk_en), .as2_reset(as2_reset), .pin_float(pin_float),
    .mode_state(mode_state));

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s: got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  // Address and data are offered together and each is dropped on its own handshake.
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] v, input logic [3:0] s);
    int n;
    logic aw_done, w_done, got;
    aw_done = 1'b0;
    w_done = 1'b0;
    got = 1'b0;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (aw_done && w_done && s_axi_bvalid === 1'b1) got = 1'b1;
      if (!aw_done && s_axi_awready === 1'b1) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!got && n < 100);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (!got) chk(32'h0, 32'h1, "write response missing");
    @(posedge aclk);
    #1;
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] a);
    int n;
    logic a_done;
    a_done = 1'b0;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (a_done && s_axi_rvalid === 1'b1) break;
      if (!a_done && s_axi_arready === 1'b1) begin
        a_done = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
    end while (n < 100);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 100) chk(32'h0, 32'h1, "read response missing");
  endtask : axi_rd

  // Events 0..3: sleep instruction, accepted interrupt, DMA address error, NMI.
  task automatic pulse(input int k);
    @(posedge aclk);
    case (k)
      0: sleep_exec <= 1'b1;
      1: irq_accepted <= 1'b1;
      2: dma_addr_error <= 1'b1;
      default: nmi <= 1'b1;
    endcase
    @(posedge aclk);
    {sleep_exec, irq_accepted, dma_addr_error, nmi} <= 4'h0;
    @(posedge aclk);
    #1;
  endtask : pulse

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    print_verdict();
  end

  initial begin
    miscompares = 0;
    cmp_count = 0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = 100'h0;
    {sleep_exec, irq_accepted, dma_addr_error, nmi, dma_busy} = 5'h00;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(WORD);
    chk(d, 32'h0, "reset value");
    chk({a_grp, b_grp}, {5'h1E, 8'hFC}, "module clocks after reset");
    // Every bit set: reserved positions must read back zero and every stop must act.
    axi_wr(WORD, 32'hFF00FF00, 4'hA);
    axi_rd(WORD);
    chk(d, {2'h0, pdmc_pkg::CTRL_B_WMASK[5:0], 8'h0, pdmc_pkg::CTRL_A_WMASK, 8'h0},
      "masked readback");
    chk({a_grp, pin_float}, 6'h02, "register A stops");
    chk(b_grp, 8'h03, "register B stops");
    axi_wr(WORD, 32'h0, 4'hA);
    chk({a_grp, b_grp}, {5'h1E, 8'hFC}, "clocks resume");
    // A DMA stop requested mid-transfer waits for the transfer to end.
    dma_busy <= 1'b1;
    axi_wr(pdmc_pkg::ADDR_CTRL_A, 32'h00001000, 4'h2);
    repeat (3) @(posedge aclk);
    chk(dma_clk_en, 1'b1, "DMA stop while busy");
    dma_busy <= 1'b0;
    repeat (3) @(posedge aclk);
    axi_rd(pdmc_pkg::ADDR_STATUS);
    chk({dma_clk_en, d[2]}, 2'b01, "DMA stop after idle");
    axi_wr(WORD, 32'h0, 4'h2);
    // Sleep entry, then each sleep wake source in turn.
    for (int k = 1; k < 4; k++) begin
      pulse(0);
      chk({core_grp, mode_state}, {5'h07, pdmc_pkg::PDMC_SLEEP}, "sleep entry");
      pulse(k);
      chk({core_grp, mode_state}, {5'h1F, pdmc_pkg::PDMC_RUN}, "sleep wake");
    end
    // Standby with and without pin float; a plain interrupt must not wake it.
    // The watchdog is not part of this block, so its stop before standby is assumed done.
    for (int f = 0; f < 2; f++) begin
      axi_wr(WORD, {16'h0, 1'b1, f[0], 6'h0, 8'h0}, 4'h2);
      pulse(0);
      chk({core_grp, pin_float, mode_state}, {5'h00, f[0], pdmc_pkg::PDMC_STANDBY},
        "standby entry");
      pulse(1);
      pulse(2);
      chk(mode_state, pdmc_pkg::PDMC_STANDBY, "standby holds");
      pulse(3);
      chk({core_grp, pin_float, mode_state}, {5'h1F, 1'b0, pdmc_pkg::PDMC_RUN},
        "standby wake");
    end
    // Unmapped address is refused and leaves the map unchanged.
    axi_wr(32'hFFFFFE98, 32'hFFFFFFFF, 4'hF);
    chk(r, pdmc_pkg::RESP_SLVERR, "unmapped write");
    axi_rd(32'hFFFFFE98);
    chk(r, pdmc_pkg::RESP_SLVERR, "unmapped read");
    axi_rd(WORD);
    chk(d, 32'h0000C000, "map after unmapped write");
    // Reset in mid-run clears both registers.
    axi_wr(WORD, 32'hFF00FF00, 4'hA);
    chk(r, pdmc_pkg::RESP_OKAY, "mapped write");
    // Standby with floating pins first, so the reset must also end standby.
    pulse(0);
    chk({pin_float, mode_state}, {1'b1, pdmc_pkg::PDMC_STANDBY},
      "standby before reset");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(WORD);
    chk(d, 32'h0, "second reset");
    chk({core_grp, pin_float, mode_state}, {5'h1F, 1'b0, pdmc_pkg::PDMC_RUN},
      "reset ends standby");
    chk({a_grp, b_grp}, {5'h1E, 8'hFC}, "clocks after second reset");
    print_verdict();
  end
endmodule : pdmc_top_tb
